// ---- bench/fwkl_flash_model.sv ----
// Flash macro: finishes each launched operation some cycles later
module fwkl_flash_model (
  input wire logic clk, // Clock
  input wire logic flash_start, // Launch
  output logic flash_done // Finished pulse
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [2:0] count_q = 3'h0;
  // Slow answer so the busy window is visible; one driver for done
  always @(posedge clk) begin
    if (flash_start) begin
      count_q <= 3'h5;
    end else if (count_q != 3'h0) begin
      count_q <= count_q - 3'h1;
    end
  end
  assign flash_done = (count_q == 3'h1);
endmodule

// ---- bench/fwkl_guard_asserts.sv ----
// Watches the guard's ports for lock and read-back relations
module fwkl_guard_chk (
  input wire logic clk, // Clock
  input wire logic rst_n, // Reset
  input wire logic [7:0] sfr_addr, // Address
  input wire logic sfr_wr, // Write
  input wire logic sfr_rd, // Read
  input wire logic [7:0] sfr_wdata, // Wdata
  input wire logic [7:0] sfr_rdata, // Rdata
  input wire logic store_wr, // Store
  input wire logic xdata_wr, // Data write
  input wire logic flash_start, // Launch
  input wire logic flash_refused, // Refusal
  input wire logic flash_locked // Lock
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  // Key accesses and reads of unmapped places
  wire key_rd = sfr_rd && sfr_addr == fwkl_pkg::KEY_ADDR;
  wire bad_key = sfr_wr && sfr_addr == fwkl_pkg::KEY_ADDR &&
    sfr_wdata != fwkl_pkg::KEY_FIRST && sfr_wdata != fwkl_pkg::KEY_SECOND;
  wire odd_rd = sfr_rd && sfr_addr != fwkl_pkg::KEY_ADDR &&
    sfr_addr != fwkl_pkg::PSCTL_ADDR;
  lock_sticky_a: assert property (flash_locked |=> flash_locked)
    else $error("lock dropped");
  bad_key_a: assert property (bad_key |=> flash_locked)
    else $error("bad key did not lock");
  refuse_lock_a: assert property (flash_refused |->
    ##[0:1] flash_locked) else $error("refusal without lock");
  one_outcome_a: assert property (store_wr |=>
    $onehot({xdata_wr, flash_start, flash_refused}))
    else $error("store write outcome wrong");
  locked_start_a: assert property (flash_locked |-> !flash_start)
    else $error("launch while locked");
  code_width_a: assert property (key_rd |=> sfr_rdata[7:2] == 6'h00)
    else $error("key read upper bits set");
  locked_code_a: assert property (key_rd && flash_locked |=>
    sfr_rdata == 8'h03) else $error("locked code wrong");
  single_op_a: assert property (flash_start |=> !flash_start[*2])
    else $error("repeated launch");
  odd_read_a: assert property (odd_rd |=> sfr_rdata == 8'h00)
    else $error("unmapped read not zero");
endmodule
bind fwkl_guard fwkl_guard_chk i_fwkl_guard_chk (.clk, .rst_n, .sfr_addr,
  .sfr_wr, .sfr_rd, .sfr_wdata, .sfr_rdata, .store_wr, .xdata_wr,
  .flash_start, .flash_refused, .flash_locked);

// ---- bench/fwkl_guard_bench.sv ----
`define CHECK(n, e, g) begin n_tests++; if ((g) !== (e)) begin n_errors++; \
  $display("unexpected %s exp %h got %h", n, e, g); end end
module fwkl_guard_bench;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk = 1'b0, rst_n = 1'b0, sfr_wr = 1'b0, sfr_rd = 1'b0;
  logic store_wr = 1'b0;
  logic [7:0] sfr_addr = 8'h00, sfr_wdata = 8'h00, store_wdata = 8'h5A;
  logic [15:0] store_addr = 16'h1234;
  logic [7:0] sfr_rdata, xdata_wdata, flash_wdata;
  logic [15:0] xdata_addr, flash_addr;
  logic xdata_wr, flash_start, flash_erase, flash_done;
  logic flash_refused, flash_locked;
  int n_errors = 0, n_tests = 0;
  localparam logic [7:0] K = fwkl_pkg::KEY_ADDR, C = fwkl_pkg::PSCTL_ADDR;
  always #10 clk = ~clk;
  fwkl_guard i_fwkl_guard (.clk, .rst_n, .sfr_addr, .sfr_wr, .sfr_rd,
    .sfr_wdata, .sfr_rdata, .store_wr, .store_addr, .store_wdata, .xdata_wr,
    .xdata_addr, .xdata_wdata, .flash_start, .flash_erase, .flash_addr,
    .flash_wdata, .flash_done, .flash_refused, .flash_locked);
  fwkl_flash_model i_fwkl_flash_model (.clk, .flash_start, .flash_done);
  task automatic tick;
    @(posedge clk);
    #1;
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    sfr_addr = a;
    sfr_wdata = d;
    sfr_wr = 1'b1;
    tick();
    sfr_wr = 1'b0;
    tick();
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    sfr_addr = a;
    sfr_rd = 1'b1;
    tick();
    sfr_rd = 1'b0;
    `CHECK("read data", e, sfr_rdata)
    tick();
  endtask
  task automatic store;
    store_wr = 1'b1;
    tick();
    store_wr = 1'b0;
  endtask
  task automatic do_reset;
    rst_n = 1'b0;
    repeat (12) tick();
    rst_n = 1'b1;
  endtask
  task automatic wrap_up;
    $display("errors %0d tests %0d", n_errors, n_tests);
    if (n_errors == 0 && n_tests > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  // Arm, run one write or erase, then fall back to data memory
  task automatic t_op(input logic [7:0] ctl, input logic er);
    int i;
    wr(K, 8'hA5);
    rd(K, 8'h01);
    wr(K, 8'hF1);
    rd(K, 8'h02);
    wr(C, ctl);
    store();
    `CHECK("launch", 1'b1, flash_start)
    `CHECK("erase", er, flash_erase)
    `CHECK("address", 16'h1234, flash_addr)
    if (!er) `CHECK("flash byte", 8'h5A, flash_wdata)
    rd(K, 8'h02);
    for (i = 0; i < 20 && flash_done !== 1'b1; i++) tick();
    if (i == 20) begin
      n_errors++;
      wrap_up();
    end
    tick();
    rd(K, 8'h00);
    wr(C, 8'h00);
    store();
    `CHECK("data write", 1'b1, xdata_wr)
    `CHECK("data address", 16'h1234, xdata_addr)
    `CHECK("data byte", 8'h5A, xdata_wdata)
    `CHECK("flash idle", 1'b0, flash_start)
    tick();
  endtask
  // Store write while disarmed, then a key pair that must not help
  task automatic t_refuse;
    wr(C, 8'h01);
    store();
    `CHECK("refused", 1'b1, flash_refused)
    `CHECK("no launch", 1'b0, flash_start)
    tick();
    wr(K, 8'hA5);
    wr(K, 8'hF1);
    rd(K, 8'h03);
    store();
    `CHECK("refused again", 1'b1, flash_refused)
    tick();
  endtask
  // Key write and store write on one edge while armed: lock wins
  task automatic t_clash;
    do_reset();
    wr(K, 8'hA5);
    wr(K, 8'hF1);
    wr(C, 8'h01);
    sfr_addr = K;
    sfr_wdata = 8'hF1;
    sfr_wr = 1'b1;
    store();
    sfr_wr = 1'b0;
    `CHECK("clash launch", 1'b0, flash_start)
    `CHECK("clash refused", 1'b1, flash_refused)
    `CHECK("clash lock", 1'b1, flash_locked)
    tick();
  endtask
  // Broken key sequences lock until reset
  task automatic t_bad(input logic [7:0] a, b, input logic two);
    do_reset();
    rd(K, 8'h00);
    wr(K, a);
    if (two) wr(K, b);
    rd(K, 8'h03);
    `CHECK("lock flag", 1'b1, flash_locked)
  endtask
  initial begin
    do_reset();
    rd(K, 8'h00);
    rd(C, 8'h00);
    rd(8'h33, 8'h00);
    t_op(8'h01, 1'b0);
    t_op(8'h03, 1'b1);
    t_refuse();
    t_clash();
    t_bad(8'hA5, 8'h00, 1'b1);
    t_bad(8'hA5, 8'hA5, 1'b1);
    t_bad(8'hF1, 8'h00, 1'b0);
    t_bad(8'h12, 8'h00, 1'b0);
    wrap_up();
  end
endmodule

// ---- hw/fwkl_guard.sv ----
module fwkl_guard (
  input wire logic clk, // System clock, 50 MHz
  input wire logic rst_n, // Asynchronous device reset, active low
  input wire logic [7:0] sfr_addr, // Register address from the core
  input wire logic sfr_wr, // Register write strobe, one cycle
  input wire logic sfr_rd, // Register read strobe, one cycle
  input wire logic [7:0] sfr_wdata, // Register write data
  output logic [7:0] sfr_rdata, // Register read data, registered
  input wire logic store_wr, // External store write strobe, one cycle
  input wire logic [15:0] store_addr, // External store address
  input wire logic [7:0] store_wdata, // External store write data
  output logic xdata_wr, // Data memory write pulse
  output logic [15:0] xdata_addr, // Data memory address
  output logic [7:0] xdata_wdata, // Data memory write data
  output logic flash_start, // Flash operation start pulse
  output logic flash_erase, // Flash operation is a page erase
  output logic [15:0] flash_addr, // Flash byte or page address
  output logic [7:0] flash_wdata, // Flash byte to program
  input wire logic flash_done, // Flash operation finished, one cycle
  output logic flash_refused, // Attempt refused, one-cycle pulse
  output logic flash_locked // Guard permanently locked, level
);
  fwkl_pkg::fwkl_state_t state_q;
  fwkl_pkg::fwkl_state_t state_d;
  logic lock_q;
  logic lock_d;
  logic [7:0] rdata_q;
  logic [7:0] rdata_d;
  logic xdata_wr_q;
  logic [15:0] xdata_addr_q;
  logic [7:0] xdata_wdata_q;
  logic flash_start_q;
  logic flash_erase_q;
  logic [15:0] flash_addr_q;
  logic [7:0] flash_wdata_q;
  logic refused_q;
  logic write_enable;
  logic erase_enable;

  // Map a guard state onto the two-bit code software reads
  function automatic logic [1:0] state_code(
    input fwkl_pkg::fwkl_state_t st,
    input logic locked
  );
    logic [1:0] code;
    code = fwkl_pkg::CODE_IDLE;
    if (locked) begin
      code = fwkl_pkg::CODE_LOCKED;
    end else begin
      unique case (st)
        fwkl_pkg::GUARD_IDLE: code = fwkl_pkg::CODE_IDLE;
        fwkl_pkg::GUARD_KEY1: code = fwkl_pkg::CODE_KEY1;
        fwkl_pkg::GUARD_ARMED: code = fwkl_pkg::CODE_ARMED;
        fwkl_pkg::GUARD_BUSY: code = fwkl_pkg::CODE_ARMED;
        fwkl_pkg::GUARD_LOCKED: code = fwkl_pkg::CODE_LOCKED;
        default: code = fwkl_pkg::CODE_LOCKED;
      endcase
    end
    return code;
  endfunction

  // Address decode of the two registers
  wire key_wr = sfr_wr && (sfr_addr == fwkl_pkg::KEY_ADDR);
  wire key_rd = sfr_rd && (sfr_addr == fwkl_pkg::KEY_ADDR);
  wire ctl_wr = sfr_wr && (sfr_addr == fwkl_pkg::PSCTL_ADDR);
  wire ctl_rd = sfr_rd && (sfr_addr == fwkl_pkg::PSCTL_ADDR);
  wire key_is_first = (sfr_wdata == fwkl_pkg::KEY_FIRST);
  wire key_is_second = (sfr_wdata == fwkl_pkg::KEY_SECOND);

  // Store writes go to flash only while the write enable is set
  // store write steering
  wire prog_wr = store_wr && write_enable;
  wire data_wr = store_wr && !write_enable;
  // permitted only when armed
  // A key write on the same edge locks, so no launch may slip out
  wire prog_ok = prog_wr && (state_q == fwkl_pkg::GUARD_ARMED) &&
    !lock_q && !key_wr;
  wire prog_bad = prog_wr && !prog_ok;

  fwkl_psctl u_psctl (
    .clk(clk),
    .rst_n(rst_n),
    .wr_en(ctl_wr),
    .wdata(sfr_wdata),
    .write_enable(write_enable),
    .erase_enable(erase_enable)
  );

  // Guard sequencing; a refused attempt or bad key wins over all else
  always_comb begin
    state_d = state_q;
    unique case (state_q)
      fwkl_pkg::GUARD_IDLE: begin
        if (key_wr) begin
          state_d = key_is_first ? fwkl_pkg::GUARD_KEY1
                                 : fwkl_pkg::GUARD_LOCKED;
        end
      end
      fwkl_pkg::GUARD_KEY1: begin
        if (key_wr) begin
          state_d = key_is_second ? fwkl_pkg::GUARD_ARMED
                                  : fwkl_pkg::GUARD_LOCKED;
        end
      end
      fwkl_pkg::GUARD_ARMED: begin
        if (key_wr) begin
          state_d = fwkl_pkg::GUARD_LOCKED;
        end else if (prog_ok) begin
          state_d = fwkl_pkg::GUARD_BUSY;
        end
      end
      fwkl_pkg::GUARD_BUSY: begin
        if (key_wr) begin
          state_d = fwkl_pkg::GUARD_LOCKED;
        end else if (flash_done) begin
          state_d = fwkl_pkg::GUARD_IDLE;
        end
      end
      fwkl_pkg::GUARD_LOCKED: state_d = fwkl_pkg::GUARD_LOCKED;
      default: state_d = fwkl_pkg::GUARD_LOCKED;
    endcase
    if (prog_bad) begin
      state_d = fwkl_pkg::GUARD_LOCKED;
    end
  end

  assign lock_d = lock_q || (state_d == fwkl_pkg::GUARD_LOCKED);

  // Read data: only the lock code is visible, never the written key
  // read returns state
  always_comb begin
    rdata_d = rdata_q;
    if (key_rd) begin
      rdata_d = {6'h00, state_code(state_q, lock_q)};
    end else if (ctl_rd) begin
      rdata_d = {6'h00, erase_enable, write_enable};
    end else if (sfr_rd) begin
      rdata_d = 8'h00;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state_q <= fwkl_pkg::GUARD_IDLE;
      lock_q <= 1'b0;
      rdata_q <= fwkl_pkg::KEY_RESET;
    end else begin
      state_q <= state_d;
      lock_q <= lock_d;
      rdata_q <= rdata_d;
    end
  end

  // Data memory path, one cycle behind the request
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      xdata_wr_q <= 1'b0;
      xdata_addr_q <= 16'h0000;
      xdata_wdata_q <= 8'h00;
    end else begin
      xdata_wr_q <= data_wr;
      if (data_wr) begin
        xdata_addr_q <= store_addr;
        xdata_wdata_q <= store_wdata;
      end
    end
  end

  // Flash launch; the data byte is meaningless for an erase
  // page erase select
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      flash_start_q <= 1'b0;
      flash_erase_q <= 1'b0;
      flash_addr_q <= 16'h0000;
      flash_wdata_q <= 8'h00;
      refused_q <= 1'b0;
    end else begin
      flash_start_q <= prog_ok;
      refused_q <= prog_bad;
      if (prog_ok) begin
        flash_erase_q <= erase_enable;
        flash_addr_q <= store_addr;
        flash_wdata_q <= store_wdata;
      end
    end
  end

  assign sfr_rdata = rdata_q;
  assign xdata_wr = xdata_wr_q;
  assign xdata_addr = xdata_addr_q;
  assign xdata_wdata = xdata_wdata_q;
  assign flash_start = flash_start_q;
  assign flash_erase = flash_erase_q;
  assign flash_addr = flash_addr_q;
  assign flash_wdata = flash_wdata_q;
  assign flash_refused = refused_q;
  assign flash_locked = lock_q;
endmodule

// ---- hw/fwkl_pkg.sv ----
// Constants shared by the program-memory write guard
package fwkl_pkg;
  // Special-function register addresses
  localparam logic [7:0] KEY_ADDR = 8'hB7;
  localparam logic [7:0] PSCTL_ADDR = 8'h8F;
  // Reset values
  localparam logic [7:0] KEY_RESET = 8'h00;
  localparam logic [1:0] PSCTL_RESET = 2'h0;
  // Key sequence values
  localparam logic [7:0] KEY_FIRST = 8'hA5;
  localparam logic [7:0] KEY_SECOND = 8'hF1;
  // Field positions in the program store control register
  localparam int PSCTL_WE_BIT = 0;
  localparam int PSCTL_EE_BIT = 1;
  // Lock state codes read back from the key register
  localparam logic [1:0] CODE_IDLE = 2'h0;
  localparam logic [1:0] CODE_KEY1 = 2'h1;
  localparam logic [1:0] CODE_ARMED = 2'h2;
  localparam logic [1:0] CODE_LOCKED = 2'h3;
  // Guard states
  typedef enum logic [2:0] {
    GUARD_IDLE,
    GUARD_KEY1,
    GUARD_ARMED,
    GUARD_BUSY,
    GUARD_LOCKED
  } fwkl_state_t;
endpackage

// ---- hw/fwkl_psctl.sv ----
// Program store control register: write and erase enable bits
module fwkl_psctl (
  input wire logic clk, // System clock
  input wire logic rst_n, // Asynchronous reset, active low
  input wire logic wr_en, // Write strobe for this register
  input wire logic [7:0] wdata, // Write data
  output logic write_enable, // Store writes target program memory
  output logic erase_enable // Store writes erase a page when write_enable is also set
);
  logic [1:0] ctl_q;
  logic [1:0] ctl_d;

  // Reserved upper bits are dropped; they always read zero
  assign ctl_d = wr_en ? wdata[1:0] : ctl_q;

  // Control bits held until software rewrites them
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ctl_q <= fwkl_pkg::PSCTL_RESET;
    end else begin
      ctl_q <= ctl_d;
    end
  end

  assign write_enable = ctl_q[fwkl_pkg::PSCTL_WE_BIT];
  assign erase_enable = ctl_q[fwkl_pkg::PSCTL_EE_BIT];
endmodule
